// File: rtl/four_level_interrupt_priority.sv
// Purpose: Four level nested interrupt arbitration for six request sources.
// Assumes: Flags and core strobes come from logic on ref_clk.
// Notes: The core takes a vector with vector_take and ends a handler with handler_return.
//
// Our own choice: the plain strobed port.
`default_nettype none

module four_level_interrupt_priority (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire prio_pkg::reg_req_t reg_req,
  output logic [7:0] rd_data,
  // Peripheral flags and trigger modes.
  input wire prio_pkg::req_flags_t flags,
  input wire logic ext_zero_edge_mode,
  input wire logic ext_one_edge_mode,
  output prio_pkg::flag_clear_t flag_clear,
  // Core sequencer.
  output logic vector_req,
  output logic [15:0] vector_addr,
  output logic [1:0] vector_level,
  input wire logic vector_take,
  input wire logic handler_return,
  // Event interrupt.
  output logic irq
);

  import prio_pkg::*;

  // Register state.
  logic [5:0] prio_high_ff;
  logic [5:0] prio_low_ff;
  logic [6:0] enable_ff;
  logic [5:0] evt_status_ff;
  logic [5:0] evt_enable_ff;
  logic [3:0] in_service_ff;
  logic [7:0] rd_data_ff;
  logic irq_ff;

  // Vector state.
  logic vector_req_ff;
  logic [15:0] vector_addr_ff;
  logic [1:0] vector_level_ff;
  logic [2:0] vector_idx_ff;
  flag_clear_t flag_clear_ff;

  // Next values.
  logic [5:0] nxt_prio_high;
  logic [5:0] nxt_prio_low;
  logic [6:0] nxt_enable;
  logic [5:0] nxt_evt_status;
  logic [5:0] nxt_evt_enable;
  logic [3:0] nxt_in_service;
  logic [7:0] nxt_rd_data;
  logic nxt_irq;
  logic nxt_vector_req;
  logic [15:0] nxt_vector_addr;
  logic [1:0] nxt_vector_level;
  logic [2:0] nxt_vector_idx;
  flag_clear_t nxt_flag_clear;

  // Decode.
  wire wr_high = reg_req.wr && reg_req.addr == ADDR_PRIO_HIGH;
  wire wr_low = reg_req.wr && reg_req.addr == ADDR_PRIO_LOW;
  wire wr_enable = reg_req.wr && reg_req.addr == ADDR_ENABLE;
  wire wr_evt_clear = reg_req.wr && reg_req.addr == ADDR_EVT_CLEAR;
  wire wr_evt_enable = reg_req.wr && reg_req.addr == ADDR_EVT_ENABLE;

  // Source request lines in polling order.
  wire [5:0] raw_req;
  wire [5:0] pending;
  wire global_enable = enable_ff[GLOBAL_ENABLE_BIT - 1]; // RULE12

  assign raw_req = {
    flags.timer_two_overflow | flags.timer_two_external_flag,
    flags.receive_done_flag | flags.transmit_done_flag,
    flags.timer_one_overflow,
    flags.external_one_request,
    flags.timer_zero_overflow,
    flags.external_zero_request
  }; // RULE1 RULE11

  assign pending = raw_req & enable_ff[SRC_FIELD_MSB:0] & {6{global_enable}}; // RULE12

  // Arbitration.
  logic win_grant;
  logic [2:0] win_idx;
  logic [1:0] win_lvl;

  level_arbiter #(
    .N(NUM_SRC)
  ) u_arb (
    .pend(pending),
    .prio_high(prio_high_ff),
    .prio_low(prio_low_ff),
    .busy(in_service_ff),
    .grant(win_grant),
    .idx(win_idx),
    .lvl(win_lvl)
  );

  // Taking and returning.
  wire take = vector_take && vector_req_ff;
  wire [3:0] take_onehot = take ? (4'b0001 << vector_level_ff) : 4'b0000;
  wire [3:0] top_service;
  wire [3:0] ret_onehot;

  // Highest level in service is the one that returns.
  assign top_service = in_service_ff[3] ? 4'b1000 :
                       in_service_ff[2] ? 4'b0100 :
                       in_service_ff[1] ? 4'b0010 :
                       in_service_ff[0] ? 4'b0001 : 4'b0000;
  assign ret_onehot = handler_return ? top_service : 4'b0000;

  // Clearing the return bit uncovers the preempted level below it.
  assign nxt_in_service = (in_service_ff & ~ret_onehot) | take_onehot; // RULE14 RULE7

  // Vector request held while the winner may be serviced.
  assign nxt_vector_req = win_grant && !take; // RULE5 RULE6
  assign nxt_vector_idx = win_idx;
  assign nxt_vector_level = win_lvl;
  assign nxt_vector_addr = VEC_BASE + VEC_STEP * {13'd0, win_idx}; // RULE9

  // Hardware flag clears on vectoring.
  assign nxt_flag_clear.external_zero_request =
    take && vector_idx_ff == 3'd0 && ext_zero_edge_mode; // RULE10
  assign nxt_flag_clear.timer_zero_overflow = take && vector_idx_ff == 3'd1; // RULE10
  assign nxt_flag_clear.external_one_request =
    take && vector_idx_ff == 3'd2 && ext_one_edge_mode; // RULE10
  assign nxt_flag_clear.timer_one_overflow = take && vector_idx_ff == 3'd3; // RULE10

  // Register writes.
  assign nxt_prio_high = wr_high ? reg_req.wdata[5:0] : prio_high_ff; // RULE3
  assign nxt_prio_low = wr_low ? reg_req.wdata[5:0] : prio_low_ff; // RULE13
  assign nxt_enable = wr_enable ? {reg_req.wdata[7], reg_req.wdata[5:0]} : enable_ff;
  assign nxt_evt_enable = wr_evt_enable ? reg_req.wdata[5:0] : evt_enable_ff;

  // Vector events are sticky; a new event wins over a clear.
  wire [5:0] evt_set = take ? (6'b00_0001 << vector_idx_ff) : 6'b00_0000;
  wire [5:0] evt_clr = wr_evt_clear ? reg_req.wdata[5:0] : 6'b00_0000;

  assign nxt_evt_status = (evt_status_ff & ~evt_clr) | evt_set;
  assign nxt_irq = |(nxt_evt_status & nxt_evt_enable);

  // Read mux; reserved bits read as zero.
  wire rd_high = reg_req.addr == ADDR_PRIO_HIGH;
  wire rd_low = reg_req.addr == ADDR_PRIO_LOW;
  wire rd_enable = reg_req.addr == ADDR_ENABLE;
  wire rd_status = reg_req.addr == ADDR_EVT_STATUS;
  wire rd_evt_en = reg_req.addr == ADDR_EVT_ENABLE;
  wire rd_svc = reg_req.addr == ADDR_IN_SERVICE;

  assign nxt_rd_data = !reg_req.rd ? 8'h00 :
                       rd_high ? {2'b00, prio_high_ff} :
                       rd_low ? {2'b00, prio_low_ff} :
                       rd_enable ? {enable_ff[6], 1'b0, enable_ff[5:0]} :
                       rd_status ? {2'b00, evt_status_ff} :
                       rd_evt_en ? {2'b00, evt_enable_ff} :
                       rd_svc ? {4'h0, in_service_ff} : 8'h00;

  // High priority bits flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prio_high_ff <= PRIO_HIGH_RST;
    end
    else
    begin
      prio_high_ff <= nxt_prio_high; // RULE3
    end
  end

  // Low priority bits flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prio_low_ff <= PRIO_LOW_RST;
    end
    else
    begin
      prio_low_ff <= nxt_prio_low; // RULE13
    end
  end

  // Enable register flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      enable_ff <= ENABLE_RST;
    end
    else
    begin
      enable_ff <= nxt_enable; // RULE12
    end
  end

  // Event enable flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      evt_enable_ff <= EVT_RST;
    end
    else
    begin
      evt_enable_ff <= nxt_evt_enable;
    end
  end

  // Event status flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      evt_status_ff <= EVT_RST;
    end
    else
    begin
      evt_status_ff <= nxt_evt_status;
    end
  end

  // Read data flop; it holds a value only in the cycle after a read.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_data_ff <= 8'h00;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Interrupt output flop.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end

  // Service tracking flops.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      in_service_ff <= IN_SERVICE_RST;
    end
    else
    begin
      in_service_ff <= nxt_in_service; // RULE14
    end
  end

  // Vector request flop; it drops in the cycle after a take.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      vector_req_ff <= 1'b0;
    end
    else
    begin
      vector_req_ff <= nxt_vector_req; // RULE5 RULE6
    end
  end

  // Flag clear pulse flop; each pulse lasts one cycle.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flag_clear_ff <= '0;
    end
    else
    begin
      flag_clear_ff <= nxt_flag_clear; // RULE10
    end
  end

  // Offered vector flops.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      vector_addr_ff <= VEC_BASE;
      vector_level_ff <= 2'd0;
      vector_idx_ff <= 3'd0;
    end
    else
    begin
      vector_addr_ff <= nxt_vector_addr;
      vector_level_ff <= nxt_vector_level;
      vector_idx_ff <= nxt_vector_idx;
    end
  end

  // Outputs straight from flops.
  assign rd_data = rd_data_ff;
  assign irq = irq_ff;
  assign vector_req = vector_req_ff;
  assign vector_addr = vector_addr_ff;
  assign vector_level = vector_level_ff;
  assign flag_clear = flag_clear_ff;

endmodule : four_level_interrupt_priority

`default_nettype wire

// File: rtl/prio_pkg.sv
// Purpose: Shared constants and carriers for the four level interrupt priority block.
// Assumes: One core clock, synchronous active low reset, register port of the core.
// Notes: How it works list follows.
// How it works
// RULE1 - Six sources: ext0, tmr0, ext1, tmr1, serial, tmr2.
// RULE2 - High and low bits give level 0 to 3.
// RULE3 - High priority bits live at address B7.
// RULE4 - Service only when nothing equal or higher runs.
// RULE5 - Lower or equal request waits for handler end.
// RULE6 - Higher level request preempts the running handler.
// RULE7 - Preempted handler resumes after the higher one.
// RULE8 - Same level: fixed polling order, ext0 first.
// RULE9 - Fixed vectors 03, 0B, 13, 1B, 23, 2B.
// RULE10 - Vectoring clears timer zero and one flags, edge external flags.
// RULE11 - Software clears serial and timer two flags.
// RULE12 - Per-source enable bits plus one global enable.
// RULE13 - Low priority bits live at address B8.
// RULE14 - Record in-service level; release it on return.
`default_nettype none

package prio_pkg;

  localparam int NUM_SRC = 6; // RULE1
  localparam int NUM_LVL = 4; // RULE2

  // Register addresses.
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7; // RULE3
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8; // RULE13
  localparam logic [7:0] ADDR_ENABLE = 8'ha8; // RULE12
  localparam logic [7:0] ADDR_EVT_STATUS = 8'hc0;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'hc1;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'hc2;
  localparam logic [7:0] ADDR_IN_SERVICE = 8'hc3;

  // Field positions.
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int SRC_FIELD_MSB = 5;

  // Reset values.
  localparam logic [5:0] PRIO_HIGH_RST = 6'h00;
  localparam logic [5:0] PRIO_LOW_RST = 6'h00;
  localparam logic [6:0] ENABLE_RST = 7'h00;
  localparam logic [5:0] EVT_RST = 6'h00;
  localparam logic [3:0] IN_SERVICE_RST = 4'h0;

  // Vector table: first vector and spacing between sources.
  localparam logic [15:0] VEC_BASE = 16'h0003; // RULE9
  localparam logic [15:0] VEC_STEP = 16'h0008; // RULE9

  // Request flags from the peripherals.
  typedef struct packed {
    logic timer_two_external_flag;
    logic timer_two_overflow;
    logic transmit_done_flag;
    logic receive_done_flag;
    logic timer_one_overflow;
    logic external_one_request;
    logic timer_zero_overflow;
    logic external_zero_request;
  } req_flags_t;

  // Hardware clear strobes back to the peripherals.
  typedef struct packed {
    logic timer_one_overflow;
    logic external_one_request;
    logic timer_zero_overflow;
    logic external_zero_request;
  } flag_clear_t;

  // Register port.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : prio_pkg

`default_nettype wire

// File: rtl/level_arbiter.sv
// Purpose: Picks the winning request by level, then polling order.
// Assumes: Pending bits already gated by the enables.
// Notes: Purely combinational.
`default_nettype none

module level_arbiter #(
  parameter int N = 6
) (
  // Requests and priority bits.
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0] prio_high,
  input wire logic [N-1:0] prio_low,
  // Levels in service.
  input wire logic [3:0] busy,
  // Winner.
  output logic grant,
  output logic [$clog2(N)-1:0] idx,
  output logic [1:0] lvl
);

  logic [1:0] src_lvl [N];
  logic found;
  logic [3:0] ge_mask;

  for (genvar g = 0; g < N; g++)
  begin : g_lvl
    assign src_lvl[g] = {prio_high[g], prio_low[g]}; // RULE2
  end

  // Later hits override: highest level wins, lowest index within it.
  always_comb
  begin
    found = 1'b0;
    idx = '0;
    lvl = 2'd0;
    for (int l = 0; l < 4; l++)
    begin
      for (int i = N - 1; i >= 0; i--)
      begin
        if (pend[i] && src_lvl[i] == 2'(l))
        begin
          found = 1'b1;
          idx = ($clog2(N))'(i); // RULE8
          lvl = 2'(l);
        end
      end
    end
  end

  assign ge_mask = 4'b1111 << lvl;
  assign grant = found && !(|(busy & ge_mask)); // RULE4 RULE6

endmodule : level_arbiter

`default_nettype wire

// File: verification/prio_chk.sv
// Purpose: Port checks for the priority block.
// Assumes: One clock, synchronous active low reset.
// Notes: Bound to the top module below.
`default_nettype none

module prio_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire prio_pkg::reg_req_t reg_req,
  input wire logic [7:0] rd_data,
  // Peripheral side.
  input wire prio_pkg::req_flags_t flags,
  input wire logic ext_zero_edge_mode,
  input wire logic ext_one_edge_mode,
  input wire prio_pkg::flag_clear_t flag_clear,
  // Core side.
  input wire logic vector_req,
  input wire logic [15:0] vector_addr,
  input wire logic [1:0] vector_level,
  input wire logic vector_take,
  input wire logic handler_return,
  input wire logic irq
);
  import prio_pkg::*;
  logic ge_ff;
  wire logic ge_wr = reg_req.wr && reg_req.addr == ADDR_ENABLE;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ge_ff <= 1'b0;
    else if (ge_wr)
      ge_ff <= reg_req.wdata[7];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; vector_take && vector_req; endsequence
  sequence s_at(a); vector_take && vector_req && vector_addr == a; endsequence
  property p_drop; s_take |=> !vector_req; endproperty
  property p_nest;
    s_take ##1 !handler_return |=> !vector_req || vector_level > $past(vector_level, 2);
  endproperty
  property p_tmr0; s_at(16'h000B) |=> flag_clear.timer_zero_overflow; endproperty
  property p_tmr1; s_at(16'h001B) |=> flag_clear.timer_one_overflow; endproperty
  property p_ext0;
    s_at(16'h0003) |=> flag_clear.external_zero_request == $past(ext_zero_edge_mode);
  endproperty
  property p_ext1;
    s_at(16'h0013) |=> flag_clear.external_one_request == $past(ext_one_edge_mode);
  endproperty
  property p_keep; s_take ##0 vector_addr > 16'h001B |=> flag_clear == 4'h0; endproperty
  property p_cause; flag_clear != 4'h0 |-> $past(vector_take && vector_req); endproperty
  property p_vec;
    vector_req |-> vector_addr inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
  endproperty
  property p_ge; !ge_ff && !$past(ge_ff) |-> !vector_req; endproperty
  a_drop: assert property (p_drop) else $error("request stays after take");
  a_nest: assert property (p_nest) else $error("offer not above in service");
  a_tmr0: assert property (p_tmr0) else $error("timer zero flag not cleared");
  a_tmr1: assert property (p_tmr1) else $error("timer one flag not cleared");
  a_ext0: assert property (p_ext0) else $error("ext zero clear wrong");
  a_ext1: assert property (p_ext1) else $error("ext one clear wrong");
  a_keep: assert property (p_keep) else $error("serial or timer two flag cleared");
  a_cause: assert property (p_cause) else $error("clear without take");
  a_vec: assert property (p_vec) else $error("bad vector");
  a_ge: assert property (p_ge) else $error("offer with global enable off");
endmodule : prio_chk

bind four_level_interrupt_priority prio_chk prio_chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data), .flags(flags),
  .ext_zero_edge_mode(ext_zero_edge_mode), .ext_one_edge_mode(ext_one_edge_mode),
  .flag_clear(flag_clear), .vector_req(vector_req), .vector_addr(vector_addr),
  .vector_level(vector_level), .vector_take(vector_take), .handler_return(handler_return),
  .irq(irq)
);

`default_nettype wire

// File: verification/flag_source.sv
// Purpose: Peripheral request flags seen by the block.
// Assumes: Bench pulses raise and lower for one cycle.
// Notes: Flags hold until a clear pulse or software.
`default_nettype none

module flag_source (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench controls.
  input wire logic [7:0] raise,
  input wire logic [7:0] lower,
  // Block side.
  input wire prio_pkg::flag_clear_t flag_clear,
  output prio_pkg::req_flags_t flags
);
  import prio_pkg::*;
  req_flags_t flags_ff;
  wire logic [7:0] nxt_flags = (flags_ff | raise) & ~lower & ~{4'h0, flag_clear};
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      flags_ff <= 8'h00;
    else
      flags_ff <= nxt_flags;
  end
  assign flags = flags_ff;
endmodule : flag_source

`default_nettype wire

// File: verification/four_level_interrupt_priority_tb_top.sv
// Purpose: Directed bench for the priority block.
// Assumes: Register port and core strobes driven on ref_clk.
// Notes: Stops on a cycle ceiling.
`default_nettype none

module four_level_interrupt_priority_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import prio_pkg::*;
  logic ref_clk, rst_n, vector_take, handler_return, vector_req, irq;
  logic ext_zero_edge_mode, ext_one_edge_mode;
  logic [7:0] raise, lower, rd_data;
  logic [15:0] vector_addr;
  logic [1:0] vector_level;
  reg_req_t reg_req;
  req_flags_t flags;
  flag_clear_t flag_clear;
  int mismatches, check_count, cyc;
  four_level_interrupt_priority four_level_interrupt_priority_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data), .flags(flags),
    .ext_zero_edge_mode(ext_zero_edge_mode), .ext_one_edge_mode(ext_one_edge_mode),
    .flag_clear(flag_clear), .vector_req(vector_req), .vector_addr(vector_addr),
    .vector_level(vector_level), .vector_take(vector_take),
    .handler_return(handler_return), .irq(irq));
  flag_source flag_source_i (.ref_clk(ref_clk), .rst_n(rst_n), .raise(raise),
    .lower(lower), .flag_clear(flag_clear), .flags(flags));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= {a, d, 2'b10};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_req <= {a, 8'h00, 2'b01};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1 chk("rd_data", 16'(e), 16'(rd_data));
    @(posedge ref_clk);
  endtask : rd
  task automatic pulse(input logic [7:0] r, input logic [7:0] l);
    raise <= r;
    lower <= l;
    @(posedge ref_clk);
    raise <= 8'h00;
    lower <= 8'h00;
    @(posedge ref_clk);
  endtask : pulse
  task automatic take(input logic [15:0] a, input logic [1:0] l);
    int n;
    n = 0;
    #1;
    while (vector_req !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("vector_req", 16'h0001, 16'(vector_req));
    chk("vector_addr", a, vector_addr);
    chk("vector_level", 16'(l), 16'(vector_level));
    @(posedge ref_clk);
    vector_take <= 1'b1;
    @(posedge ref_clk);
    vector_take <= 1'b0;
    @(posedge ref_clk);
  endtask : take
  task automatic ret;
    handler_return <= 1'b1;
    @(posedge ref_clk);
    handler_return <= 1'b0;
    @(posedge ref_clk);
  endtask : ret
  task automatic no_req;
    repeat (3) @(posedge ref_clk);
    #1 chk("vector_req", 16'h0000, 16'(vector_req));
  endtask : no_req
  logic [7:0] ra [7] = '{8'hb7, 8'hb8, 8'ha8, 8'hc0, 8'hc2, 8'hc3, 8'h55};
  initial
  begin
    {rst_n, vector_take, handler_return, raise, lower, reg_req} = '0;
    {ext_zero_edge_mode, ext_one_edge_mode} = 2'b11;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(8'hb7, 8'hff);
    rd(8'hb7, 8'h3f);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h3f);
    wr(8'ha8, 8'hff);
    rd(8'ha8, 8'hbf);
    wr(8'hb7, 8'h00);
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h3f);
    pulse(8'h02, 8'h00);
    no_req();
    wr(8'ha8, 8'h80);
    no_req();
    wr(8'ha8, 8'hbf);
    take(16'h000B, 2'd0);
    ret();
    $display("enable test done");
    pulse(8'h5f, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      take(16'h0003 + 16'(8 * i), 2'd0);
      if (i >= 4)
        pulse(8'h00, (i == 4) ? 8'h10 : 8'h40);
      ret();
    end
    chk("flags", 16'h0000, 16'(flags));
    ext_zero_edge_mode <= 1'b0;
    pulse(8'h01, 8'h00);
    take(16'h0003, 2'd0);
    #1 chk("flags", 16'h0001, 16'(flags));
    pulse(8'h00, 8'h01);
    ext_zero_edge_mode <= 1'b1;
    ret();
    $display("vector test done");
    rd(8'hc0, 8'h3f);
    wr(8'hc0, 8'h00);
    rd(8'hc0, 8'h3f);
    wr(8'hc2, 8'h01);
    chk("irq", 16'h0001, 16'(irq));
    wr(8'hc1, 8'h01);
    chk("irq", 16'h0000, 16'(irq));
    rd(8'hc0, 8'h3e);
    wr(8'hc2, 8'h02);
    chk("irq", 16'h0001, 16'(irq));
    wr(8'hc2, 8'h00);
    chk("irq", 16'h0000, 16'(irq));
    $display("event test done");
    wr(8'hb8, 8'h0c);
    wr(8'hb7, 8'h06);
    pulse(8'h08, 8'h00);
    take(16'h001B, 2'd1);
    pulse(8'h02, 8'h00);
    take(16'h000B, 2'd2);
    pulse(8'h05, 8'h00);
    take(16'h0013, 2'd3);
    rd(8'hc3, 8'h0e);
    pulse(8'h04, 8'h00);
    no_req();
    ret();
    take(16'h0013, 2'd3);
    ret();
    rd(8'hc3, 8'h06);
    no_req();
    ret();
    rd(8'hc3, 8'h02);
    ret();
    take(16'h0003, 2'd0);
    ret();
    rd(8'hc3, 8'h00);
    $display("nesting test done");
    end_sim();
  end
endmodule : four_level_interrupt_priority_tb_top

`default_nettype wire
